// ---- logic/tcc_pkg.sv ----
// constants for the capture, compare and gated timer block
// assumes a 32-bit AHB-Lite slave port and a single 100 MHz clock
// How it works
// - mode 4 capture, 5 compare, 6 gated
// - capture mode counts; pin change raises capture
// - next cycle copy count, set flag, stay on
// - capture never stops or resets the count
// - capture mode match: reload one, set flag
// - capture and rollover share flag; irq gated
// - reset clears count; later capture and gated periods reload one
// - count writes ignored while clock gated off
// - written count governs only the first period
// - enable readback shows one only once effective
// - capture source select in second control register
// - polarity sets inactive input level
// - compare period end reloads zero, keeps counting
// - wrap-at-all-ones text loses to zero reload
// - period ends on edge after count equals compare
// - compare end toggles output; pin needs enable
// - interrupt enable lives in second control register
// - gated mode counts only at active input level
// - gated end reloads one, toggles, sets flag
// - flag cleared by writing one; no double irq
// - count write clears write-done, then sets it
package tcc_pkg;
   localparam logic [7:0] OFS_COUNT = 8'h00;
   localparam logic [7:0] OFS_MATCH = 8'h04;
   localparam logic [7:0] OFS_CAPT = 8'h08;
   localparam logic [7:0] OFS_FLAG = 8'h0C;
   localparam logic [7:0] OFS_CTRLA = 8'h10;
   localparam logic [7:0] OFS_CTRLB = 8'h18;
   // flag register fields
   localparam int FLAG_IRQ = 0;
   localparam int FLAG_WRDONE = 8;
   // primary control fields
   localparam int CA_MODE_LO = 0;
   localparam int CA_CLKEN = 4;
   localparam int CA_POL = 5;
   localparam int CA_EN = 7;
   // secondary control fields
   localparam int CB_CAPSEL_LO = 0;
   localparam int CB_IRQEN = 2;
   localparam int CB_OUTEN = 3;
   // modes
   localparam logic [3:0] MODE_CAPTURE = 4'h4;
   localparam logic [3:0] MODE_COMPARE = 4'h5;
   localparam logic [3:0] MODE_GATED = 4'h6;
   // capture sources
   localparam logic [1:0] CAP_ANY = 2'h0;
   localparam logic [1:0] CAP_RISE = 2'h1;
   localparam logic [1:0] CAP_FALL = 2'h2;
   // reset and reload values
   localparam logic [31:0] CNT_RESET = 32'h0000_0000;
   localparam logic [31:0] RELOAD_ONE = 32'h0000_0001;
   localparam logic [31:0] RELOAD_ZERO = 32'h0000_0000;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_LAST} tcc_bus_t;
endpackage

// ---- logic/tcc_timer.sv ----
// capture, compare and gated timer with an AHB-Lite register slave
// assumes one clock, an asynchronous input pin and an external pad buffer
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module tcc_timer
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic tmrIn,
   output logic tmrOut,
   output logic irqOut
);
   import tcc_pkg::*;

   // ==========================================================
   // reset release
   logic rstA_q;
   logic rstB_q;
   logic rstn;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rstA_q <= 1'b0;
         rstB_q <= 1'b0;
      end
      else
      begin
         rstA_q <= 1'b1;
         rstB_q <= rstA_q;
      end
   end
   assign rstn = rstB_q;

   // ==========================================================
   // register state
   logic [31:0] count_q;
   logic [31:0] matchLimit_q;
   logic [31:0] captured_q;
   logic irqFlag_q;
   logic wrDone_q;
   logic wrPend_q;
   logic [3:0] mode_q;
   logic clkEn_q;
   logic pol_q;
   logic en_q;
   logic enStat_q;
   logic [1:0] capSel_q;
   logic irqEn_q;
   logic outEn_q;
   logic outState_q;
   logic capPend_q;

   // ==========================================================
   // bus slave
   tcc_bus_t busSt_q;
   logic [7:0] addr_q;
   logic wr_q;
   logic [31:0] rdData_q;
   logic ready_q;
   logic wrStb;
   logic [31:0] rdMux;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         busSt_q <= BUS_IDLE;
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         ready_q <= 1'b1;
      end
      else
      begin
         case (busSt_q)
            BUS_IDLE:
            begin
               if (hsel && htrans[1] && hready)
               begin
                  addr_q <= haddr;
                  wr_q <= hwrite;
                  ready_q <= 1'b0;
                  busSt_q <= BUS_WAIT;
               end
            end
            BUS_WAIT:
            begin
               ready_q <= 1'b1;
               busSt_q <= BUS_LAST;
            end
            BUS_LAST:
            begin
               if (hsel && htrans[1] && hready)
               begin
                  addr_q <= haddr;
                  wr_q <= hwrite;
                  ready_q <= 1'b0;
                  busSt_q <= BUS_WAIT;
               end
               else
               begin
                  busSt_q <= BUS_IDLE;
               end
            end
            default:
            begin
               busSt_q <= BUS_IDLE;
            end
         endcase
      end
   end
   assign wrStb = (busSt_q == BUS_WAIT) && wr_q;

   always_comb
   begin
      rdMux = REG_RESET;
      case (addr_q)
         OFS_COUNT: rdMux = count_q;
         OFS_MATCH: rdMux = matchLimit_q;
         OFS_CAPT: rdMux = captured_q;
         OFS_FLAG:
         begin
            rdMux[FLAG_IRQ] = irqFlag_q;
            rdMux[FLAG_WRDONE] = wrDone_q;
         end
         OFS_CTRLA:
         begin
            rdMux[CA_MODE_LO +: 4] = mode_q;
            rdMux[CA_CLKEN] = clkEn_q;
            rdMux[CA_POL] = pol_q;
            rdMux[CA_EN] = enStat_q;
         end
         OFS_CTRLB:
         begin
            rdMux[CB_CAPSEL_LO +: 2] = capSel_q;
            rdMux[CB_IRQEN] = irqEn_q;
            rdMux[CB_OUTEN] = outEn_q;
         end
         default: rdMux = REG_RESET;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdData_q <= REG_RESET;
      end
      else if (busSt_q == BUS_WAIT && !wr_q)
      begin
         rdData_q <= rdMux;
      end
   end

   assign hrdata = rdData_q;
   assign hreadyout = ready_q;
   assign hresp = 1'b0;

   // ==========================================================
   // control registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_q <= 4'h0;
         clkEn_q <= 1'b0;
         pol_q <= 1'b0;
         en_q <= 1'b0;
         capSel_q <= CAP_ANY;
         irqEn_q <= 1'b0;
         outEn_q <= 1'b0;
         matchLimit_q <= REG_RESET;
      end
      else if (wrStb)
      begin
         if (addr_q == OFS_CTRLA)
         begin
            mode_q <= hwdata[CA_MODE_LO +: 4];
            clkEn_q <= hwdata[CA_CLKEN];
            pol_q <= hwdata[CA_POL];
            en_q <= hwdata[CA_EN];
         end
         if (addr_q == OFS_CTRLB)
         begin
            capSel_q <= hwdata[CB_CAPSEL_LO +: 2];
            irqEn_q <= hwdata[CB_IRQEN];
            outEn_q <= hwdata[CB_OUTEN];
         end
         if (addr_q == OFS_MATCH)
         begin
            matchLimit_q <= hwdata;
         end
      end
   end

   // enable reads back only once the timer runs with it
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         enStat_q <= 1'b0;
      end
      else
      begin
         enStat_q <= en_q;
      end
   end

   // ==========================================================
   // input pin synchroniser
   logic inA_q;
   logic inB_q;
   logic inC_q;
   logic inLvl_q;
   logic inRise;
   logic inFall;
   logic active;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         inA_q <= 1'b0;
         inB_q <= 1'b0;
         inC_q <= 1'b0;
      end
      else
      begin
         inA_q <= tmrIn;
         inB_q <= inA_q;
         inC_q <= inB_q;
      end
   end

   // level counts once second and third stages agree
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         inLvl_q <= 1'b0;
      end
      else if (inB_q == inC_q)
      begin
         inLvl_q <= inC_q;
      end
   end
   assign inRise = (inB_q == inC_q) && inC_q && !inLvl_q;
   assign inFall = (inB_q == inC_q) && !inC_q && inLvl_q;
   assign active = inLvl_q != pol_q;

   // ==========================================================
   // counting
   logic tick;
   logic match;
   logic cntWr;
   logic periodEnd;
   logic capEvt;
   logic isCap;
   logic isCmp;
   logic isGate;
   assign tick = en_q && clkEn_q;
   assign match = count_q == matchLimit_q;
   assign cntWr = wrStb && (addr_q == OFS_COUNT) && clkEn_q;
   assign isCap = mode_q == MODE_CAPTURE;
   assign isCmp = mode_q == MODE_COMPARE;
   assign isGate = mode_q == MODE_GATED;
   assign periodEnd = tick && match && (isCap || isCmp || isGate);

   always_comb
   begin
      case (capSel_q)
         CAP_RISE: capEvt = inRise;
         CAP_FALL: capEvt = inFall;
         default: capEvt = inRise || inFall;
      endcase
      capEvt = capEvt && tick && isCap;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count_q <= CNT_RESET;
      end
      else if (cntWr)
      begin
         count_q <= hwdata;
      end
      else if (tick)
      begin
         if (isCap)
         begin
            count_q <= match ? RELOAD_ONE : count_q + 32'h0000_0001;
         end
         else if (isCmp)
         begin
            count_q <= match ? RELOAD_ZERO : count_q + 32'h0000_0001;
         end
         else if (isGate)
         begin
            if (match)
            begin
               count_q <= RELOAD_ONE;
            end
            else if (active)
            begin
               count_q <= count_q + 32'h0000_0001;
            end
         end
      end
   end

   // capture register loads the cycle after the event
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         capPend_q <= 1'b0;
         captured_q <= REG_RESET;
      end
      else
      begin
         capPend_q <= capEvt;
         if (capPend_q)
         begin
            captured_q <= count_q;
         end
         else if (wrStb && addr_q == OFS_CAPT && clkEn_q)
         begin
            captured_q <= hwdata;
         end
      end
   end

   // ==========================================================
   // flags and outputs
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irqFlag_q <= 1'b0;
      end
      else if (periodEnd || capPend_q)
      begin
         irqFlag_q <= 1'b1;
      end
      else if (wrStb && addr_q == OFS_FLAG && hwdata[FLAG_IRQ])
      begin
         irqFlag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wrDone_q <= 1'b0;
         wrPend_q <= 1'b0;
      end
      else
      begin
         wrPend_q <= cntWr;
         if (cntWr)
         begin
            wrDone_q <= 1'b0;
         end
         else if (wrPend_q)
         begin
            wrDone_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         outState_q <= 1'b0;
      end
      else if (periodEnd && (isCmp || isGate))
      begin
         outState_q <= !outState_q;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tmrOut <= 1'b0;
         irqOut <= 1'b0;
      end
      else
      begin
         tmrOut <= outEn_q ? (outState_q ^ pol_q) : pol_q;
         irqOut <= irqFlag_q && irqEn_q;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   capReload_a: assert property ((tick && isCap && match && !cntWr) |=> count_q == RELOAD_ONE)
      else $error("capture rollover did not reload one");
   cmpZero_a: assert property ((tick && isCmp && match && !cntWr) |=> count_q == RELOAD_ZERO)
      else $error("compare period end did not reload zero");
   capCopy_a: assert property (capEvt |=> ##1 captured_q == $past(count_q))
      else $error("capture register missed count");
   flagSet_a: assert property ((periodEnd || capPend_q) |=> irqFlag_q)
      else $error("period event flag not set");
   irqGate_a: assert property (##1 irqOut == $past(irqFlag_q && irqEn_q))
      else $error("interrupt output not gated by enable");
   wrIgnore_a: assert property ((wrStb && addr_q == OFS_COUNT && !clkEn_q) |=> $stable(count_q))
      else $error("count write taken while clock gated");
   wrDone_a: assert property (cntWr |=> !wrDone_q ##1 wrDone_q)
      else $error("write done sequence wrong");
   gateHold_a: assert property ((tick && isGate && !active && !match && !cntWr) |=> $stable(count_q))
      else $error("gated count moved while inactive");
   enStat_a: assert property ($rose(en_q) |-> !enStat_q ##1 enStat_q)
      else $error("enable readback timing wrong");
   outFollow_a: assert property ((!outEn_q ##1 !outEn_q) |-> tmrOut == $past(pol_q))
      else $error("output pin driven while disabled");

   capture_c: cover property (capPend_q && match);
   cmpEnd_c: cover property (periodEnd && isCmp && outEn_q);
   gateEnd_c: cover property (periodEnd && isGate && irqEn_q);
   flagRace_c: cover property (periodEnd && wrStb && addr_q == OFS_FLAG);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the capture, compare and gated timer
// assumes one 100 MHz clock and a single AHB-Lite master in the bench
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import tcc_pkg::*;
   logic clk, nrst, hsel, hwrite, pinLvl, hreadyout, hresp, tmrIn, tmrOut, irqOut;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd, m, seed, a, b, nChg, gap;
   int n_mismatch, compares;
   logic [7:0] ofsList [0:6] = '{OFS_COUNT, OFS_MATCH, OFS_CAPT, OFS_FLAG, OFS_CTRLA,
      OFS_CTRLB, 8'h1C};
   tcc_timer tcc_timer_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .tmrIn(tmrIn), .tmrOut(tmrOut), .irqOut(irqOut));
   tcc_pin_model tcc_pin_model_i (.clk(clk), .drive(pinLvl), .tmrOut(tmrOut),
      .tmrIn(tmrIn), .nChg(nChg), .gap(gap));
   // =========================================
   // clock and helpers
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] ctl(input logic [3:0] md, input logic en, input logic pol);
      ctl = {28'h0, md} | (32'h1 << CA_CLKEN) | ({31'h0, pol} << CA_POL) | ({31'h0, en} << CA_EN);
   endfunction
   function automatic logic [31:0] periodOf(input logic [3:0] md, input logic [31:0] lim);
      periodOf = (md == MODE_COMPARE) ? lim + 32'h1 : lim;
   endfunction
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         n_mismatch++;
      end
   endtask
   // =========================================
   // AHB-Lite master
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= ad;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      bus(1'b1, ad, d);
   endtask
   task automatic rdc(input logic [7:0] ad, input string name, input logic [31:0] exp);
      bus(1'b0, ad, 32'h0);
      chk(name, exp, rd);
   endtask
   task automatic poll(input logic [7:0] ad, input int bitNo, input string name);
      int t;
      t = 0;
      bus(1'b0, ad, 32'h0);
      while (rd[bitNo] !== 1'b1 && t < 20)
      begin
         bus(1'b0, ad, 32'h0);
         t++;
      end
      chk(name, 32'h1, {31'h0, rd[bitNo]});
   endtask
   task automatic waitChg(input logic [31:0] n, input int lim);
      int t;
      t = 0;
      while (nChg < n && t < lim)
      begin
         @(posedge clk);
         t++;
      end
      chk("output toggle seen", 32'h1, {31'h0, nChg >= n});
   endtask
   task automatic stopClear(input logic [3:0] md);
      wr(OFS_CTRLA, ctl(md, 1'b0, 1'b0));
      wr(OFS_FLAG, 32'h1);
   endtask
   // =========================================
   // main sequence
   initial
   begin
      nrst = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 8'h00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pinLvl = 1'b0;
      seed = 32'hD08E;
      n_mismatch = 0;
      compares = 0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (ofsList[i])
         rdc(ofsList[i], "reset value", REG_RESET);
      m = 32'd20 + ($random(seed) & 32'hF);
      wr(OFS_COUNT, 32'h5);
      chk("okay response", 32'h0, {31'h0, hresp});
      rdc(OFS_COUNT, "count write while gated", CNT_RESET);
      wr(OFS_CTRLA, ctl(4'h0, 1'b0, 1'b0));
      wr(OFS_COUNT, m - 32'h2);
      poll(OFS_FLAG, FLAG_WRDONE, "write done");
      rdc(OFS_COUNT, "start count", m - 32'h2);
      // compare mode: short first period, then full periods from zero
      wr(OFS_MATCH, m);
      wr(OFS_CTRLB, (32'h1 << CB_IRQEN) | (32'h1 << CB_OUTEN));
      wr(OFS_CTRLA, ctl(MODE_COMPARE, 1'b1, 1'b0));
      poll(OFS_CTRLA, CA_EN, "enable readback");
      waitChg(32'h1, 8);
      waitChg(32'h2, 200);
      chk("compare period", periodOf(MODE_COMPARE, m), gap);
      waitChg(32'h3, 200);
      chk("compare period again", periodOf(MODE_COMPARE, m), gap);
      chk("irq enabled", 32'h1, {31'h0, irqOut});
      stopClear(MODE_COMPARE);
      rdc(OFS_FLAG, "flag cleared", 32'h1 << FLAG_WRDONE);
      chk("irq after clear", 32'h0, {31'h0, irqOut});
      // capture mode: rising edges only, interrupt masked
      wr(OFS_CTRLB, {30'h0, CAP_RISE});
      wr(OFS_MATCH, 32'h0000_FFFF);
      wr(OFS_CTRLA, ctl(MODE_CAPTURE, 1'b1, 1'b0));
      poll(OFS_CTRLA, CA_EN, "enable readback");
      pinLvl <= 1'b1;
      repeat (12) @(posedge clk);
      bus(1'b0, OFS_CAPT, 32'h0);
      a = rd;
      chk("capture in range", 32'h1, {31'h0, a > 32'h0 && a < 32'd40});
      rdc(OFS_FLAG, "capture flag", (32'h1 << FLAG_WRDONE) | 32'h1);
      chk("irq masked", 32'h0, {31'h0, irqOut});
      bus(1'b0, OFS_COUNT, 32'h0);
      chk("count runs on", 32'h1, {31'h0, rd > a});
      wr(OFS_FLAG, 32'h1);
      pinLvl <= 1'b0;
      repeat (12) @(posedge clk);
      rdc(OFS_FLAG, "falling ignored", 32'h1 << FLAG_WRDONE);
      // capture rollover
      stopClear(MODE_CAPTURE);
      wr(OFS_MATCH, m);
      // start below the compare value, else the count runs past it and never rolls over
      wr(OFS_COUNT, CNT_RESET);
      poll(OFS_FLAG, FLAG_WRDONE, "write done again");
      wr(OFS_CTRLA, ctl(MODE_CAPTURE, 1'b1, 1'b0));
      repeat (70) @(posedge clk);
      bus(1'b0, OFS_COUNT, 32'h0);
      chk("rollover bound", 32'h1, {31'h0, rd >= RELOAD_ONE && rd <= m});
      rdc(OFS_FLAG, "rollover flag", (32'h1 << FLAG_WRDONE) | 32'h1);
      // undefined mode holds count
      stopClear(MODE_CAPTURE);
      wr(OFS_CTRLA, ctl(4'h7, 1'b1, 1'b0));
      bus(1'b0, OFS_COUNT, 32'h0);
      a = rd;
      rdc(OFS_COUNT, "mode 7 holds", a);
      // gated mode: inactive input holds, active input counts
      stopClear(4'h7);
      wr(OFS_CTRLB, 32'h1 << CB_OUTEN);
      wr(OFS_CTRLA, ctl(MODE_GATED, 1'b1, 1'b0));
      bus(1'b0, OFS_COUNT, 32'h0);
      a = rd;
      rdc(OFS_COUNT, "gated hold", a);
      b = nChg;
      pinLvl <= 1'b1;
      waitChg(b + 32'h2, 300);
      chk("gated period", periodOf(MODE_GATED, m), gap);
      rdc(OFS_FLAG, "gated flag", (32'h1 << FLAG_WRDONE) | 32'h1);
      chk("gated irq masked", 32'h0, {31'h0, irqOut});
      stopClear(MODE_GATED);
      test_done;
   end
   // =========================================
   // watchdog
   initial
   begin
      #100000;
      n_mismatch++;
      test_done;
   end
endmodule
`default_nettype wire

// ---- tb/tcc_pin_model.sv ----
// external timer pin: drives the input level, times output toggles
// assumes the bench sets the level just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_model
(
   input wire logic clk,
   input wire logic drive,
   input wire logic tmrOut,
   output logic tmrIn,
   output logic [31:0] nChg,
   output logic [31:0] gap
);
   logic [31:0] run = 32'h0;
   logic lastOut = 1'b0;
   // =========================================
   // input pin, idle at the programmed level
   assign tmrIn = drive;
   // =========================================
   // output toggle counter and spacing
   // counts only clean changes, so the unknown level before reset is not a toggle
   always @(posedge clk)
   begin
      lastOut <= tmrOut;
      if ((tmrOut ^ lastOut) === 1'b1)
      begin
         nChg <= nChg + 32'h1;
         gap <= run + 32'h1;
         run <= 32'h0;
      end
      else
         run <= run + 32'h1;
   end
   initial nChg = 32'h0;
   initial gap = 32'h0;
endmodule
`default_nettype wire
